// file: rtl/ebc_device.sv
module ebc_device (
  input wire logic i_clock,
  input wire logic i_rst,
  ebc_if.device bus,
  input wire logic [ebc_pkg::PAGE_CODE_W-1:0] i_page_size,
  input wire logic [ebc_pkg::ID_W-1:0] i_processor_id,
  input wire logic i_acc_req,
  input wire logic i_acc_write,
  input wire logic [ebc_pkg::ADDR_W-1:0] i_acc_addr,
  input wire logic [ebc_pkg::DATA_W-1:0] i_acc_wdata,
  input wire logic i_acc_last,
  output logic o_acc_take,
  output logic o_acc_done,
  output logic [ebc_pkg::DATA_W-1:0] o_acc_rdata,
  output logic o_host_owns,
  output logic [ebc_pkg::ADDR_W-1:0] o_mem_addr,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [ebc_pkg::DATA_W-1:0] o_mem_wdata,
  input wire logic [ebc_pkg::DATA_W-1:0] i_mem_rdata,
  input wire logic i_mem_wait
);
  import ebc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ebc_dev_state_e state_reg, state_next;
  logic hbr_meta_reg, hbr_sync_reg;
  logic susp_reg;
  logic [ID_W-1:0] id_reg;
  logic id_caught_reg;
  logic [ADDR_W-1:0] addr_reg, cnt_reg, last_page_reg;
  logic [DATA_W-1:0] wdata_reg, rdata_reg;
  logic write_reg, last_reg, burst_mode_reg, page_reg;
  logic [ADDR_W-1:0] slv_cnt_reg;
  logic slv_first_reg, rvalid_reg;
  logic host_req, peer_ahead, mp_ok, start, xfer_done, advance, driving;
  logic [ADDR_W-1:0] new_addr, slv_addr;
  logic h_rd, h_wr, slv_active, ack_low, slv_done;

  // ----------------------------------------------------------------
  // Input capture
  // ----------------------------------------------------------------
  // Host request is asynchronous, so it gets two flops
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      hbr_meta_reg <= 1'b1;
      hbr_sync_reg <= 1'b1;
      susp_reg <= 1'b0;
    end else begin
      hbr_meta_reg <= bus.host_bus_request_n;
      hbr_sync_reg <= hbr_meta_reg;
      susp_reg <= ~bus.bus_suspend_n;
    end
  end

  // Strap caught once after reset release, never under reset
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      id_reg <= '0;
      id_caught_reg <= 1'b0;
    end else if (!id_caught_reg) begin
      id_reg <= i_processor_id;
      id_caught_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  assign host_req = ~hbr_sync_reg;

  // Fixed priority: lower processor number wins
  always_comb begin
    peer_ahead = 1'b0;
    for (int i = 0; i < NUM_PROC; i++) begin
      if ((i + 1) < int'(id_reg) && !bus.processor_bus_requests[i]) begin
        peer_ahead = 1'b1;
      end
    end
  end

  assign mp_ok = ~peer_ahead & ~host_req;

  // Own request line, only on a numbered processor
  assign bus.dev_br_oe = (id_reg != '0);
  assign bus.dev_br_n = (state_reg == DS_ARB || state_reg == DS_ACCESS) ?
                        ~(NUM_PROC'(1) << (id_reg - 3'h1)) : '1;

  // ----------------------------------------------------------------
  // Master sequencing
  // ----------------------------------------------------------------
  assign start = (state_reg == DS_ARB) && mp_ok && !susp_reg;
  assign xfer_done = (state_reg == DS_ACCESS) && bus.ack && !susp_reg;
  assign advance = xfer_done && !last_reg && !host_req;
  assign new_addr = start ? i_acc_addr : cnt_reg + ADDR_W'(1);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DS_IDLE: begin
        if (host_req) begin
          state_next = DS_RELEASE;
        end else if (i_acc_req) begin
          state_next = DS_ARB;
        end
      end
      DS_ARB: begin
        if (host_req) begin
          state_next = DS_RELEASE;
        end else if (start) begin
          state_next = DS_ACCESS;
        end
      end
      DS_ACCESS: begin
        if (xfer_done && host_req) begin
          state_next = DS_RELEASE;
        end else if (xfer_done && last_reg) begin
          state_next = DS_IDLE;
        end
      end
      DS_RELEASE: begin
        state_next = DS_GRANTED;
      end
      DS_GRANTED: begin
        if (!host_req) begin
          state_next = DS_IDLE;
        end
      end
      default: begin
        state_next = DS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= DS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Address held through a burst; a flagless pair sends word two alone
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      addr_reg <= '0;
      cnt_reg <= '0;
      wdata_reg <= '0;
      write_reg <= 1'b0;
      last_reg <= 1'b0;
    end else if (start || advance) begin
      if (start) begin
        write_reg <= i_acc_write;
      end
      addr_reg <= (start || (!burst_mode_reg && i_acc_last)) ? new_addr : addr_reg;
      cnt_reg <= new_addr;
      wdata_reg <= i_acc_wdata;
      last_reg <= i_acc_last;
    end
  end

  // Burst mode entered once the first word is through
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      burst_mode_reg <= 1'b0;
    end else if (state_next != DS_ACCESS) begin
      burst_mode_reg <= 1'b0;
    end else if (advance) begin
      burst_mode_reg <= 1'b1;
    end
  end

  // Page check on every word; only bank zero may hold DRAM
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      page_reg <= 1'b0;
      last_page_reg <= PAGE_RESET;
    end else if (start || advance) begin
      page_reg <= (ebc_bank_of(new_addr) == DRAM_BANK) &&
                  (ebc_page_of(new_addr, i_page_size) != last_page_reg);
      if (ebc_bank_of(new_addr) == DRAM_BANK) begin
        last_page_reg <= ebc_page_of(new_addr, i_page_size);
      end
    end else if (state_next != DS_ACCESS) begin
      page_reg <= 1'b0;
    end
  end

  // Read data caught on the acknowledged edge
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_acc_rdata <= '0;
    end else if (xfer_done && !write_reg) begin
      o_acc_rdata <= bus.data;
    end
  end

  assign o_acc_take = start || advance;
  assign o_acc_done = xfer_done;
  assign o_host_owns = (state_reg == DS_GRANTED);

  // ----------------------------------------------------------------
  // Pin drive; outside an access or when suspended the master pins float (grant and slave read data excepted)
  // ----------------------------------------------------------------
  assign driving = (state_reg == DS_ACCESS) && !susp_reg;
  assign bus.dev_addr = addr_reg;
  assign bus.dev_addr_oe = driving;
  assign bus.dev_sel_n = ~(NUM_BANKS'(1) << ebc_bank_of(addr_reg));
  assign bus.dev_sel_oe = driving;
  assign bus.dev_rd_n = write_reg ? '1 : '0;
  assign bus.dev_wr_n = write_reg ? '0 : '1;
  assign bus.dev_strb_oe = driving;
  assign bus.dev_burst = burst_mode_reg && !last_reg;
  assign bus.dev_burst_oe = driving;
  assign bus.dev_page = page_reg;
  assign bus.dev_page_oe = driving;
  assign bus.dev_data = o_host_owns ? rdata_reg : wdata_reg;
  assign bus.dev_data_oe = (driving && write_reg) || (o_host_owns && h_rd && rvalid_reg);
  // Grant floats one cycle while handing over
  assign bus.dev_grant_n = ~o_host_owns;
  assign bus.dev_grant_oe = o_host_owns || (state_reg == DS_ACCESS);

  // ----------------------------------------------------------------
  // Host access to internal memory
  // ----------------------------------------------------------------
  assign h_rd = ~&bus.read_strobes;
  assign h_wr = ~&bus.write_strobes;
  assign slv_active = o_host_owns && (h_rd || h_wr);
  assign slv_addr = (slv_first_reg && !bus.burst_flag) ? bus.addr : slv_cnt_reg;
  // A read costs one wait state so the data leaves a flop
  assign ack_low = slv_active && (h_rd ? !rvalid_reg : i_mem_wait);
  assign slv_done = slv_active && !ack_low;
  assign bus.dev_ack_oe = ack_low;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      slv_first_reg <= 1'b1;
      slv_cnt_reg <= '0;
    end else if (!slv_active) begin
      slv_first_reg <= 1'b1;
    end else if (slv_done) begin
      slv_first_reg <= ~bus.burst_flag;
      slv_cnt_reg <= slv_addr + ADDR_W'(1);
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
    end else if (slv_done || !slv_active) begin
      rvalid_reg <= 1'b0;
    end else if (h_rd && !rvalid_reg && !i_mem_wait) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= i_mem_rdata;
    end
  end

  assign o_mem_addr = slv_addr;
  assign o_mem_rd = slv_active && h_rd && !rvalid_reg;
  assign o_mem_wr = slv_active && h_wr && !i_mem_wait;
  assign o_mem_wdata = bus.data;

endmodule : ebc_device

// file: common/ebc_pkg.sv
package ebc_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;
  localparam int NUM_PROC = 6;
  localparam int ID_W = 3;
  localparam int STRB_W = 2;

  // ----------------------------------------------------------------
  // Page size: code n selects 2**(PAGE_MIN_SHIFT+n) words per page
  // ----------------------------------------------------------------
  localparam int PAGE_CODE_W = 3;
  localparam int PAGE_MIN_SHIFT = 8;
  localparam logic [BANK_W-1:0] DRAM_BANK = 2'h0;
  localparam logic [ADDR_W-1:0] PAGE_RESET = 32'hffffffff;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;

  // ----------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    DS_IDLE = 5'b00001,
    DS_ARB = 5'b00010,
    DS_ACCESS = 5'b00100,
    DS_RELEASE = 5'b01000,
    DS_GRANTED = 5'b10000
  } ebc_dev_state_e;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_OWN = 3'b010,
    HS_ACCESS = 3'b100
  } ebc_host_state_e;

  // Page number of an address for a given page size code
  function automatic logic [ADDR_W-1:0] ebc_page_of(input logic [ADDR_W-1:0] addr,
                                                   input logic [PAGE_CODE_W-1:0] code);
    ebc_page_of = addr >> (PAGE_MIN_SHIFT + int'(code));
  endfunction : ebc_page_of

  // Bank index decoded from the top address bits
  function automatic logic [BANK_W-1:0] ebc_bank_of(input logic [ADDR_W-1:0] addr);
    ebc_bank_of = addr[ADDR_W-1 -: BANK_W];
  endfunction : ebc_bank_of

endpackage : ebc_pkg

// file: common/ebc_if.sv
interface ebc_if;
  import ebc_pkg::*;

  // ----------------------------------------------------------------
  // Per-driver values and enables
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] dev_addr, host_addr;
  logic dev_addr_oe, host_addr_oe;
  logic [DATA_W-1:0] dev_data, host_data;
  logic dev_data_oe, host_data_oe;
  logic [NUM_BANKS-1:0] dev_sel_n;
  logic dev_sel_oe;
  logic [STRB_W-1:0] dev_rd_n, dev_wr_n, host_rd_n, host_wr_n;
  logic dev_strb_oe, host_strb_oe;
  logic dev_burst, dev_burst_oe, host_burst, host_burst_oe;
  logic dev_ack_oe, host_ack_oe;
  logic dev_page, dev_page_oe;
  logic dev_grant_n, dev_grant_oe;
  logic [NUM_PROC-1:0] dev_br_n;
  logic dev_br_oe;
  logic [NUM_PROC-1:0] peer_br_n;
  logic bus_suspend_n;
  logic host_bus_request_n;

  // ----------------------------------------------------------------
  // Resolved wire levels; pulled-up lines idle high
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data;
  logic [NUM_BANKS-1:0] memory_bank_selects;
  logic [STRB_W-1:0] read_strobes, write_strobes;
  logic burst_flag, ack, page_boundary, host_bus_grant_n;
  logic [NUM_PROC-1:0] processor_bus_requests;

  assign addr = dev_addr_oe ? dev_addr : (host_addr_oe ? host_addr : '0);
  assign data = dev_data_oe ? dev_data : (host_data_oe ? host_data : '0);
  assign memory_bank_selects = dev_sel_oe ? dev_sel_n : '1;
  assign read_strobes = (dev_strb_oe ? dev_rd_n : '1) & (host_strb_oe ? host_rd_n : '1);
  assign write_strobes = (dev_strb_oe ? dev_wr_n : '1) & (host_strb_oe ? host_wr_n : '1);
  assign burst_flag = (dev_burst_oe & dev_burst) | (host_burst_oe & host_burst);
  // Open drain: either end pulls low
  assign ack = ~(dev_ack_oe | host_ack_oe);
  assign page_boundary = dev_page_oe & dev_page;
  assign host_bus_grant_n = dev_grant_oe ? dev_grant_n : 1'b1;
  assign processor_bus_requests = peer_br_n & (dev_br_oe ? dev_br_n : '1);

  modport device (
    output dev_addr, dev_addr_oe, dev_data, dev_data_oe, dev_sel_n, dev_sel_oe,
    output dev_rd_n, dev_wr_n, dev_strb_oe, dev_burst, dev_burst_oe, dev_ack_oe,
    output dev_page, dev_page_oe, dev_grant_n, dev_grant_oe, dev_br_n, dev_br_oe,
    input addr, data, read_strobes, write_strobes, burst_flag, ack,
    input bus_suspend_n, host_bus_request_n, processor_bus_requests
  );

  modport host (
    output host_addr, host_addr_oe, host_data, host_data_oe, host_rd_n, host_wr_n,
    output host_strb_oe, host_burst, host_burst_oe, host_ack_oe,
    output bus_suspend_n, host_bus_request_n,
    input addr, data, memory_bank_selects, read_strobes, write_strobes, burst_flag,
    input ack, page_boundary, host_bus_grant_n
  );

endinterface : ebc_if

// file: rtl/ebc_host.sv
module ebc_host (
  input wire logic i_clock,
  input wire logic i_rst,
  ebc_if.host bus,
  input wire logic i_want_bus,
  input wire logic i_suspend_req,
  output logic o_granted,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [ebc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [ebc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_last,
  output logic o_take,
  output logic o_done,
  output logic [ebc_pkg::DATA_W-1:0] o_rdata,
  output logic [ebc_pkg::ADDR_W-1:0] o_slv_addr,
  output logic o_slv_rd,
  output logic o_slv_wr,
  output logic [ebc_pkg::DATA_W-1:0] o_slv_wdata,
  input wire logic [ebc_pkg::DATA_W-1:0] i_slv_rdata,
  input wire logic i_slv_wait
);
  import ebc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ebc_host_state_e state_reg, state_next;
  logic [ADDR_W-1:0] addr_reg, slv_cnt_reg;
  logic [DATA_W-1:0] wdata_reg, srdata_reg;
  logic write_reg, last_reg, burst_mode_reg, slv_first_reg, rvalid_reg;
  logic start, xfer_done, advance;
  logic d_rd, d_wr, slv_active, ack_low, slv_done;
  logic [ADDR_W-1:0] slv_addr;

  // ----------------------------------------------------------------
  // Bus ownership and sequencing
  // ----------------------------------------------------------------
  assign bus.host_bus_request_n = ~i_want_bus;
  assign bus.bus_suspend_n = ~i_suspend_req;
  assign o_granted = i_want_bus && !bus.host_bus_grant_n;
  assign start = (state_reg == HS_OWN) && i_req && o_granted;
  assign xfer_done = (state_reg == HS_ACCESS) && bus.ack;
  assign advance = xfer_done && !last_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      HS_IDLE: begin
        if (o_granted) begin
          state_next = HS_OWN;
        end
      end
      HS_OWN: begin
        if (!o_granted) begin
          state_next = HS_IDLE;
        end else if (start) begin
          state_next = HS_ACCESS;
        end
      end
      HS_ACCESS: begin
        if (xfer_done && last_reg) begin
          state_next = HS_OWN;
        end
      end
      default: begin
        state_next = HS_IDLE;
      end
    endcase
  end

  // Address stays at the first word of a burst
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= HS_IDLE;
      addr_reg <= '0;
      wdata_reg <= '0;
      write_reg <= 1'b0;
      last_reg <= 1'b0;
      burst_mode_reg <= 1'b0;
      o_rdata <= '0;
    end else begin
      state_reg <= state_next;
      if (start) begin
        addr_reg <= i_addr;
        write_reg <= i_write;
      end else if (advance && !burst_mode_reg && i_last) begin
        // A two-word run never raises the flag, so word two goes out as a single access
        addr_reg <= addr_reg + ADDR_W'(1);
      end
      if (start || advance) begin
        wdata_reg <= i_wdata;
        last_reg <= i_last;
      end
      burst_mode_reg <= (state_next == HS_ACCESS) && (burst_mode_reg || advance);
      if (xfer_done && !write_reg) begin
        o_rdata <= bus.data;
      end
    end
  end

  assign o_take = start || advance;
  assign o_done = xfer_done;
  assign bus.host_addr = addr_reg;
  assign bus.host_addr_oe = (state_reg == HS_ACCESS);
  assign bus.host_rd_n = write_reg ? '1 : '0;
  assign bus.host_wr_n = write_reg ? '0 : '1;
  assign bus.host_strb_oe = (state_reg == HS_ACCESS);
  assign bus.host_burst = burst_mode_reg && !last_reg;
  assign bus.host_burst_oe = (state_reg == HS_ACCESS);

  // ----------------------------------------------------------------
  // Memory side for device-driven accesses
  // ----------------------------------------------------------------
  assign d_rd = ~&bus.read_strobes && !bus.host_strb_oe;
  assign d_wr = ~&bus.write_strobes && !bus.host_strb_oe;
  assign slv_active = ~&bus.memory_bank_selects && (d_rd || d_wr);
  // Counter used while the flag is up and for the word after a flagged one
  assign slv_addr = (slv_first_reg && !bus.burst_flag) ? bus.addr : slv_cnt_reg;
  // Wait states from the memory; reads add one for the data flop
  assign ack_low = slv_active && (i_slv_wait || (d_rd && !rvalid_reg));
  assign slv_done = slv_active && !ack_low;
  assign bus.host_ack_oe = ack_low;
  assign bus.host_data = (state_reg == HS_ACCESS) ? wdata_reg : srdata_reg;
  assign bus.host_data_oe = ((state_reg == HS_ACCESS) && write_reg) || (d_rd && rvalid_reg);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      slv_first_reg <= 1'b1;
      slv_cnt_reg <= '0;
      rvalid_reg <= 1'b0;
      srdata_reg <= '0;
    end else begin
      if (!slv_active) begin
        slv_first_reg <= 1'b1;
      end else if (slv_done) begin
        slv_first_reg <= ~bus.burst_flag;
        slv_cnt_reg <= slv_addr + ADDR_W'(1);
      end
      if (slv_done || !slv_active) begin
        rvalid_reg <= 1'b0;
      end else if (d_rd && !rvalid_reg && !i_slv_wait) begin
        rvalid_reg <= 1'b1;
        srdata_reg <= i_slv_rdata;
      end
    end
  end

  assign o_slv_addr = slv_addr;
  assign o_slv_rd = slv_active && d_rd && !rvalid_reg && !i_slv_wait;
  assign o_slv_wr = slv_active && d_wr && !i_slv_wait;
  assign o_slv_wdata = bus.data;

endmodule : ebc_host

// file: bench/ebc_sva.sv
module ebc_sva (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic dev_addr_oe,
  input wire logic dev_data_oe,
  input wire logic dev_sel_oe,
  input wire logic dev_strb_oe,
  input wire logic dev_grant_oe,
  input wire logic dev_ack_oe,
  input wire logic bus_suspend_n,
  input wire logic host_bus_request_n,
  input wire logic host_bus_grant_n,
  input wire logic page_boundary,
  input wire logic [ebc_pkg::ADDR_W-1:0] addr,
  input wire logic [ebc_pkg::NUM_BANKS-1:0] memory_bank_selects,
  input wire logic ack
);
  import ebc_pkg::*;
  // ----------------------------------------------------------------
  // One clock domain, so one default clocking
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wire logic drv_any = dev_addr_oe | dev_sel_oe | dev_strb_oe;
  wire logic sel_on = dev_sel_oe & ~&memory_bank_selects;

  a_suspend_floats: assert property (!bus_suspend_n |=> !(drv_any | dev_data_oe))
    else $error("bus driven after suspend");
  a_grant_floats: assert property (!host_bus_grant_n |-> !drv_any)
    else $error("bus driven while host granted");
  a_grant_holds: assert property (!host_bus_grant_n && !host_bus_request_n |=> !host_bus_grant_n)
    else $error("grant dropped early");
  a_grant_gap: assert property ($fell(host_bus_grant_n) |-> !$past(dev_grant_oe))
    else $error("grant without float cycle");
  a_grant_timely: assert property ($fell(host_bus_request_n) |-> ##[1:60] !host_bus_grant_n)
    else $error("no grant");
  a_page_bank: assert property (page_boundary |-> addr[ADDR_W-1 -: BANK_W] == DRAM_BANK)
    else $error("page flag outside bank 0");
  a_page_master: assert property (page_boundary |-> host_bus_grant_n)
    else $error("page flag while not master");
  a_wait_selects: assert property (!ack && sel_on && bus_suspend_n |=> $stable(memory_bank_selects))
    else $error("selects moved in wait state");
  a_ack_slave: assert property (dev_ack_oe |-> !host_bus_grant_n)
    else $error("ack driven outside host access");
endmodule : ebc_sva

// file: bench/test_external_bus_control_signals.sv
module test_external_bus_control_signals;
  timeunit 1ns;
  timeprecision 1ns;
  import ebc_pkg::*;
  logic i_clock, i_rst, want, susp, wr, last, mwait, swait, req_d, req_h;
  logic tk_d, tk_h, dn_d, dn_h, granted, pg_prev, mrd, mwr, srd, swr, owns;
  logic [1:0] rp;
  logic [2:0] psize;
  logic [ADDR_W-1:0] ad, maddr, saddr;
  logic [DATA_W-1:0] wd, rd_d, rd_h, mwd, swd;
  logic [95:0] wq[$];
  logic [95:0] rq[$];
  int err_count, num_checks, seed, pg_cnt, dn_cnt, t;

  ebc_if ebc_if_i ();
  assign ebc_if_i.peer_br_n = '1;
  ebc_device ebc_device_i (.i_clock(i_clock), .i_rst(i_rst), .bus(ebc_if_i),
    .i_page_size(psize), .i_processor_id(3'h0), .i_acc_req(req_d), .i_acc_write(wr),
    .i_acc_addr(ad), .i_acc_wdata(wd), .i_acc_last(last), .o_acc_take(tk_d),
    .o_acc_done(dn_d), .o_acc_rdata(rd_d), .o_host_owns(owns), .o_mem_addr(maddr),
    .o_mem_rd(mrd), .o_mem_wr(mwr), .o_mem_wdata(mwd), .i_mem_rdata({32'h0, maddr}),
    .i_mem_wait(mwait));
  ebc_host ebc_host_i (.i_clock(i_clock), .i_rst(i_rst), .bus(ebc_if_i), .i_want_bus(want),
    .i_suspend_req(susp), .o_granted(granted), .i_req(req_h), .i_write(wr), .i_addr(ad),
    .i_wdata(wd), .i_last(last), .o_take(tk_h), .o_done(dn_h), .o_rdata(rd_h),
    .o_slv_addr(saddr), .o_slv_rd(srd), .o_slv_wr(swr), .o_slv_wdata(swd),
    .i_slv_rdata({32'h0, saddr}), .i_slv_wait(swait));
  ebc_sva ebc_sva_i (.i_clock(i_clock), .i_rst(i_rst), .dev_addr_oe(ebc_if_i.dev_addr_oe),
    .dev_data_oe(ebc_if_i.dev_data_oe), .dev_sel_oe(ebc_if_i.dev_sel_oe),
    .dev_strb_oe(ebc_if_i.dev_strb_oe), .dev_grant_oe(ebc_if_i.dev_grant_oe),
    .dev_ack_oe(ebc_if_i.dev_ack_oe), .bus_suspend_n(ebc_if_i.bus_suspend_n),
    .host_bus_request_n(ebc_if_i.host_bus_request_n),
    .host_bus_grant_n(ebc_if_i.host_bus_grant_n), .page_boundary(ebc_if_i.page_boundary),
    .addr(ebc_if_i.addr), .memory_bank_selects(ebc_if_i.memory_bank_selects),
    .ack(ebc_if_i.ack));

  // ----------------------------------------------------------------
  // Compare, verdict and clock
  // ----------------------------------------------------------------
  task check(input string nm, input logic [95:0] seen, input logic [95:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  task complete_run;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  initial begin
    i_clock = 0;
    forever #20 i_clock = ~i_clock;
  end

  // Random slave waits keep both ends honest about acknowledge
  always @(negedge i_clock) begin
    mwait = ($random(seed) % 4) == 0;
    swait = ($random(seed) % 4) == 0;
  end

  // Monitor samples just after the falling edge, once the waits have moved
  always begin
    @(negedge i_clock);
    #1;
    pg_cnt += int'(ebc_if_i.page_boundary && !pg_prev);
    pg_prev = ebc_if_i.page_boundary;
    if (rp != 0) check("rdata", {32'h0, rp[1] ? rd_h : rd_d}, rq.pop_front());
    rp = {dn_h, dn_d} & {2{!wr}};
    dn_cnt += int'(dn_d | dn_h);
    if ((swr && !swait) || (mwr && !mwait))
      check("write", swr ? {saddr, swd} : {maddr, mwd}, wq.pop_front());
  end

  // ----------------------------------------------------------------
  // Burst driver for either end; expected words noted at take
  // ----------------------------------------------------------------
  task automatic run(input logic h, input logic w, input logic [31:0] a, input int n);
    int k;
    logic got;
    k = 0;
    @(negedge i_clock);
    wr = w;
    ad = a;
    wd = {$random(seed), $random(seed)};
    last = (n == 1);
    if (h) req_h = 1; else req_d = 1;
    // Take is read once falling-edge inputs settle; the word is captured at
    // the next rising edge, so the next word is shown only after that edge
    while (k < n) begin
      #1;
      got = h ? tk_h : tk_d;
      if (got) begin
        if (w) wq.push_back({ad, wd}); else rq.push_back({32'h0, 32'h0, ad});
        k++;
      end
      @(negedge i_clock);
      if (got) begin
        ad = a + 32'(k);
        wd = {$random(seed), $random(seed)};
        last = (k == n - 1);
        if (k == n) begin
          req_h = 0;
          req_d = 0;
        end
      end
    end
    while (wq.size() + rq.size() > 0) @(negedge i_clock);
  endtask : run

  initial begin
    #2000000;
    err_count++;
    complete_run;
  end

  initial begin
    seed = 95;
    {want, susp, wr, last, req_d, req_h, pg_prev, rp, ad, wd} = '0;
    {err_count, num_checks, pg_cnt, dn_cnt} = '0;
    psize = 3'($random(seed));
    i_rst = 1;
    repeat (8) @(negedge i_clock);
    i_rst = 0;
    repeat (2) @(negedge i_clock);
    run(0, 1, 32'h10, 3);
    check("page", 96'(pg_cnt), 96'h1);
    run(0, 0, 32'h40000020, 2);
    check("page", 96'(pg_cnt), 96'h1);
    run(0, 1, 32'h14, 1);
    check("page", 96'(pg_cnt), 96'h1);
    run(0, 0, 32'h1 << (PAGE_MIN_SHIFT + int'(psize)), 2);
    check("page", 96'(pg_cnt), 96'h2);
    run(0, 1, 32'h3 << (PAGE_MIN_SHIFT + int'(psize) - 1), 1);
    check("page", 96'(pg_cnt), 96'h2);
    $display("test page done");
    susp = 1;
    t = dn_cnt;
    fork
      run(0, 1, 32'h40000100, 2);
      begin
        repeat (12) @(negedge i_clock);
        check("stall", 96'(dn_cnt - t), 96'h0);
        susp = 0;
      end
    join
    // Suspend in mid burst: no word may finish while the bus floats
    fork
      run(0, 1, 32'h40000200, 4);
      begin
        @(posedge ebc_if_i.dev_addr_oe);
        @(negedge i_clock);
        susp = 1;
        @(negedge i_clock);
        t = dn_cnt;
        repeat (10) @(negedge i_clock);
        check("stall", 96'(dn_cnt - t), 96'h0);
        susp = 0;
      end
    join
    $display("test suspend done");
    want = 1;
    for (t = 0; t < 50 && granted !== 1'b1; t++) @(negedge i_clock);
    check("grant", {ebc_if_i.host_bus_grant_n, owns}, 96'h1);
    run(1, 1, 32'h300, 3);
    run(1, 0, 32'h300, 4);
    want = 0;
    repeat (8) @(negedge i_clock);
    check("release", {ebc_if_i.host_bus_grant_n, owns}, 96'h2);
    $display("test host done");
    for (int i = 0; i < 6; i++) run(0, 1'($random(seed)), {18'h0, 10'($random(seed)), 4'h0},
      1 + ($random(seed) & 3));
    $display("test random done");
    complete_run;
  end
endmodule : test_external_bus_control_signals
